// [core/awt_regs.sv]
// audio wake and trim register bank at nibble addresses 10h..13h
// assumes processor access: one-cycle wr_en/rd_en strobes, synchronous inputs
module awt_regs (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [4:0] addr,
   input  wire logic       wr_en,
   input  wire logic [3:0] wr_data,
   input  wire logic       rd_en,
   output logic      [3:0] rd_data,
   input  wire logic       trim_option,
   input  wire logic       halt_wake_spk,
   input  wire logic       low_voltage_sense,
   input  wire logic [3:0] sample_hi,
   output logic      [7:0] record_gain,
   output logic            record_gain_enable,
   output logic signed [3:0] osc_trim_pct,
   output logic            speaker_wake_enable,
   output logic      [1:0] wake_sensitivity_select,
   output logic            low_voltage_detect_enable,
   output logic            sample_format_select,
   output logic      [3:0] sample_hi_twos
);
   logic [3:0] gain_trim_reg;
   logic [3:0] fmt_reg;
   logic [2:0] wake_ctl_reg;
   logic       speaker_wake_flag_reg;
   logic       lvd_en_reg;
   logic       low_voltage_flag_reg;
   logic [7:0] gain_reg;
   logic signed [3:0] trim_reg;
   logic [3:0] rd_reg;
   logic [3:0] rd_next;
   logic       wr_gt;
   logic       wr_fmt;
   logic       wr_sw;
   logic       wr_vm;

   awt_ctl_if ctl ();

   assign wr_gt  = wr_en && (addr == awt_pkg::ADDR_GAIN_TRIM);
   assign wr_fmt = wr_en && (addr == awt_pkg::ADDR_AUDIO_FMT);
   assign wr_sw  = wr_en && (addr == awt_pkg::ADDR_SPK_WAKE);
   assign wr_vm  = wr_en && (addr == awt_pkg::ADDR_VOLT_MON);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gain_trim_reg <= awt_pkg::RESET_VAL;
      end else if (wr_gt) begin
         gain_trim_reg <= wr_data;
      end
   end

   // unused bits 2 and 0 are kept as written
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fmt_reg <= awt_pkg::RESET_VAL;
      end else if (wr_fmt) begin
         fmt_reg <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wake_ctl_reg <= awt_pkg::RESET_VAL[2:0];
      end else if (wr_sw) begin
         wake_ctl_reg <= wr_data[2:0];
      end
   end

   // only an enabled speaker wake sets the flag; set beats clear [RL5] [RL6]
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         speaker_wake_flag_reg <= awt_pkg::RESET_VAL[0];
      end else if (halt_wake_spk && wake_ctl_reg[awt_pkg::SW_EN_BIT]) begin
         speaker_wake_flag_reg <= 1'b1;
      end else if (wr_sw && !wr_data[awt_pkg::SW_FLAG_BIT]) begin
         speaker_wake_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lvd_en_reg <= awt_pkg::RESET_VAL[0];
      end else if (wr_vm) begin
         lvd_en_reg <= wr_data[awt_pkg::VM_EN_BIT];
      end
   end

   // flag follows the detector, never the write data [RL8] [RL10]
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         low_voltage_flag_reg <= awt_pkg::RESET_VAL[0];
      end else begin
         low_voltage_flag_reg <= lvd_en_reg && low_voltage_sense;
      end
   end

   // gain lookup, zero while gain is off [RL1] [RL3]
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gain_reg <= {2{awt_pkg::RESET_VAL}};
      end else if (!fmt_reg[awt_pkg::AF_GAIN_EN_BIT]) begin
         gain_reg <= 8'h00;
      end else begin
         unique case (gain_trim_reg[awt_pkg::GT_GAIN_LO +: 2])
            2'b00: gain_reg <= awt_pkg::GAIN_CODE0;
            2'b01: gain_reg <= awt_pkg::GAIN_CODE1;
            2'b10: gain_reg <= awt_pkg::GAIN_CODE2;
            2'b11: gain_reg <= awt_pkg::GAIN_CODE3;
         endcase
      end
   end

   // trim shift, zero unless the option is fitted [RL2]
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trim_reg <= signed'(awt_pkg::RESET_VAL);
      end else if (!trim_option) begin
         trim_reg <= 4'sh0;
      end else begin
         unique case (gain_trim_reg[awt_pkg::GT_TRIM_LO +: 2])
            2'b00: trim_reg <= awt_pkg::TRIM_CODE0;
            2'b01: trim_reg <= awt_pkg::TRIM_CODE1;
            2'b10: trim_reg <= awt_pkg::TRIM_CODE2;
            2'b11: trim_reg <= awt_pkg::TRIM_CODE3;
         endcase
      end
   end

   always_comb begin
      rd_next = rd_reg;
      if (rd_en) begin
         unique case (addr)
            awt_pkg::ADDR_GAIN_TRIM: rd_next = gain_trim_reg;
            awt_pkg::ADDR_AUDIO_FMT: rd_next = fmt_reg;
            awt_pkg::ADDR_SPK_WAKE:  rd_next = {speaker_wake_flag_reg, wake_ctl_reg};
            awt_pkg::ADDR_VOLT_MON:  rd_next = {2'b00, low_voltage_flag_reg, lvd_en_reg};
            default:                 rd_next = 4'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_reg <= awt_pkg::RESET_VAL;
      end else begin
         rd_reg <= rd_next;
      end
   end

   assign ctl.fmt_twos  = fmt_reg[awt_pkg::AF_FMT_BIT];
   assign ctl.hi_nibble = sample_hi;

   awt_sample_conv u_conv (
      .clk   (clk),
      .rst_n (rst_n),
      .ctl   (ctl.conv)
   );

   assign rd_data                   = rd_reg;
   assign record_gain               = gain_reg;
   assign record_gain_enable        = fmt_reg[awt_pkg::AF_GAIN_EN_BIT];   // [RL3]
   assign osc_trim_pct              = trim_reg;
   assign speaker_wake_enable       = wake_ctl_reg[awt_pkg::SW_EN_BIT];   // [RL6]
   assign wake_sensitivity_select   = wake_ctl_reg[awt_pkg::SW_SENS_LO +: 2]; // [RL7]
   assign low_voltage_detect_enable = lvd_en_reg;                         // [RL10]
   assign sample_format_select      = fmt_reg[awt_pkg::AF_FMT_BIT];       // [RL4]
   assign sample_hi_twos            = ctl.conv_nibble;
endmodule // awt_regs

// [core/awt_pkg.sv]
// constants, field layout and reset values of the audio wake and trim register bank
// assumes a 4-bit processor data bus with 5-bit nibble addresses
// Functional notes
// RL1 - with record gain on, gain select 00/01/10/11 picks gain 50/100/150/200.
// RL2 - with the trim option on, trim select 00/01/10/11 moves the oscillator by -4/-2/+2/+4 percent.
// RL3 - record gain enable 1 turns the built-in record gain on, 0 turns it off.
// RL4 - sample format 1 means two's complement samples, 0 means sign-magnitude.
// RL5 - a speaker wake-up from halt sets the speaker wake flag, which stays until software clears it.
// RL6 - speaker wake enable 1 allows wake-up through the speaker pins, 0 blocks it.
// RL7 - wake sensitivity 00 is the lowest detection level and 11 the highest.
// RL8 - the low-voltage flag reads 1 while supply is below the level and ignores writes.
// RL9 - in sign-magnitude the top bit of the sample high nibble is the sign, 0 positive.
// RL10 - detector enable 1 turns the detector on; 0 turns it off and keeps the flag low.
package awt_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 4;
   localparam logic [4:0] ADDR_GAIN_TRIM  = 5'h10;
   localparam logic [4:0] ADDR_AUDIO_FMT  = 5'h11;
   localparam logic [4:0] ADDR_SPK_WAKE   = 5'h12;
   localparam logic [4:0] ADDR_VOLT_MON   = 5'h13;
   localparam logic [3:0] RESET_VAL       = 4'h0;
   // field positions
   localparam int unsigned GT_TRIM_LO     = 0;
   localparam int unsigned GT_GAIN_LO     = 2;
   localparam int unsigned AF_FMT_BIT     = 1;
   localparam int unsigned AF_GAIN_EN_BIT = 3;
   localparam int unsigned SW_EN_BIT      = 0;
   localparam int unsigned SW_SENS_LO     = 1;
   localparam int unsigned SW_FLAG_BIT    = 3;
   localparam int unsigned VM_EN_BIT      = 0;
   localparam int unsigned VM_FLAG_BIT    = 1;
   localparam int unsigned SIGN_BIT       = 3;
   // record gain values per code
   localparam logic [7:0] GAIN_CODE0 = 8'h32;
   localparam logic [7:0] GAIN_CODE1 = 8'h64;
   localparam logic [7:0] GAIN_CODE2 = 8'h96;
   localparam logic [7:0] GAIN_CODE3 = 8'hc8;
   // oscillator shift in percent, signed
   localparam logic signed [3:0] TRIM_CODE0 = -4'sd4;
   localparam logic signed [3:0] TRIM_CODE1 = -4'sd2;
   localparam logic signed [3:0] TRIM_CODE2 = 4'sd2;
   localparam logic signed [3:0] TRIM_CODE3 = 4'sd4;
   typedef enum logic {AWT_SIGN_MAG = 1'b0, AWT_TWOS = 1'b1} awt_fmt_t;
endpackage : awt_pkg

// [core/awt_ctl_if.sv]
// decoded control settings passed from the bank to the sample converter
// assumes a single clock domain
interface awt_ctl_if;
   logic       fmt_twos;
   logic [3:0] hi_nibble;
   logic [3:0] conv_nibble;
   modport bank (output fmt_twos, output hi_nibble, input conv_nibble);
   modport conv (input fmt_twos, input hi_nibble, output conv_nibble);
endinterface : awt_ctl_if

// [core/awt_sample_conv.sv]
// converts the sample high nibble to two's complement for the modulator
// assumes synchronous active-low reset
module awt_sample_conv (
   input wire logic clk,
   input wire logic rst_n,
   awt_ctl_if.conv  ctl
);
   logic [3:0] conv_reg;
   logic [3:0] conv_next;

   always_comb begin
      conv_next = ctl.hi_nibble;
      // sign-magnitude: top bit is sign, 0 positive [RL9]
      if (!ctl.fmt_twos && ctl.hi_nibble[awt_pkg::SIGN_BIT]) begin // [RL4]
         conv_next = 4'(-{1'b0, ctl.hi_nibble[2:0]});
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conv_reg <= awt_pkg::RESET_VAL;
      end else begin
         conv_reg <= conv_next;
      end
   end

   assign ctl.conv_nibble = conv_reg;
endmodule // awt_sample_conv

// [tb/awt_regs_assertions.sv]
// port checks for the audio wake and trim register bank
// assumes one clock and a synchronous active-low reset
module awt_regs_assertions (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [4:0]        addr,
   input wire logic              wr_en,
   input wire logic [3:0]        wr_data,
   input wire logic              rd_en,
   input wire logic [3:0]        rd_data,
   input wire logic              trim_option,
   input wire logic              halt_wake_spk,
   input wire logic              low_voltage_sense,
   input wire logic [3:0]        sample_hi,
   input wire logic [7:0]        record_gain,
   input wire logic              record_gain_enable,
   input wire logic signed [3:0] osc_trim_pct,
   input wire logic              speaker_wake_enable,
   input wire logic [1:0]        wake_sensitivity_select,
   input wire logic              low_voltage_detect_enable,
   input wire logic              sample_format_select,
   input wire logic [3:0]        sample_hi_twos
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] TRIM [4] = '{4'hc, 4'he, 4'h2, 4'h4};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_gain_value: assert property (wr_en && addr == 5'h10 ##1 record_gain_enable |=>
      record_gain == 8'h32 * ({6'h0, $past(wr_data[3:2], 2)} + 8'h1)) else $error("gain value");
   a_trim_shift: assert property (wr_en && addr == 5'h10 && trim_option ##1 trim_option |=>
      osc_trim_pct == TRIM[$past(wr_data[1:0], 2)]) else $error("trim shift");
   a_gain_enable: assert property (wr_en && addr == 5'h11 |=>
      record_gain_enable == $past(wr_data[3])) else $error("gain enable");
   a_gain_off: assert property (!record_gain_enable |=> record_gain == 8'h0)
      else $error("gain not off");
   a_fmt_select: assert property (wr_en && addr == 5'h11 |=>
      sample_format_select == $past(wr_data[1])) else $error("format bit");
   a_wake_bits: assert property (wr_en && addr == 5'h12 |=>
      {wake_sensitivity_select, speaker_wake_enable} == $past(wr_data[2:0]))
      else $error("wake bits");
   a_wake_flag: assert property (halt_wake_spk && speaker_wake_enable
      ##1 !(wr_en && addr == 5'h12) ##1 rd_en && addr == 5'h12 |=> rd_data[3])
      else $error("wake flag");
   a_lv_flag: assert property (low_voltage_sense && low_voltage_detect_enable
      ##1 rd_en && addr == 5'h13 |=> rd_data[1]) else $error("low voltage flag");
   a_lv_off: assert property (!low_voltage_detect_enable ##1 rd_en && addr == 5'h13
      |=> !rd_data[1]) else $error("flag with detector off");
   a_sign_conv: assert property ((!sample_format_select && $stable(sample_hi)
      && sample_hi[3])[*3] |-> sample_hi_twos == 4'h0 - {1'b0, sample_hi[2:0]})
      else $error("sign conversion");
   c_gain_write: cover property (wr_en && addr == 5'h10 && record_gain_enable);
   c_flag_read: cover property (rd_en && addr == 5'h12 ##1 rd_data[3]);
   c_lv_read: cover property (rd_en && addr == 5'h13 ##1 rd_data[1]);
   c_set_clear: cover property (halt_wake_spk && speaker_wake_enable && wr_en
      && addr == 5'h12 && !wr_data[3]);
endmodule // awt_regs_assertions
bind awt_regs awt_regs_assertions awt_regs_assertions_i (.*);

// [tb/tb.sv]
// self-checking bench for the audio wake and trim register bank
// assumes registered outputs on one clock, inputs driven 1 ns after the edge
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst_n, wr_en, rd_en, trim_option, halt_wake_spk, low_voltage_sense;
   logic [4:0] addr;
   logic [3:0] wr_data, rd_data, sample_hi, sample_hi_twos, osc_trim_pct;
   logic [7:0] record_gain;
   logic [1:0] wake_sensitivity_select;
   logic       record_gain_enable, speaker_wake_enable, low_voltage_detect_enable;
   logic       sample_format_select;
   int         mismatches, total_checks, cycles;
   logic [3:0] tr [4] = '{4'hc, 4'he, 4'h2, 4'h4};
   awt_regs awt_regs_i (.*);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [3:0] d);
      step(1);
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      step(1);
      wr_en = 1'b0;
   endtask
   task automatic rd(logic [4:0] a, logic [3:0] exp);
      step(1);
      addr = a;
      rd_en = 1'b1;
      step(1);
      rd_en = 1'b0;
      step(1);
      chk({4'h0, rd_data}, {4'h0, exp});
   endtask
   task automatic pulse();
      halt_wake_spk = 1'b1;
      step(1);
      halt_wake_spk = 1'b0;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      {rst_n, wr_en, rd_en, trim_option, halt_wake_spk, low_voltage_sense} = '0;
      {addr, wr_data, sample_hi} = '0;
      step(2);
      rst_n = 1'b1;
      wr(5'h14, 4'hf);
      for (int a = 16; a < 21; a++) rd(5'(a), 4'h0);
      wr(5'h10, 4'h3);
      step(2);
      chk({4'h0, osc_trim_pct}, 8'h0);
      trim_option = 1'b1;
      wr(5'h11, 4'h8);
      chk({7'h0, record_gain_enable}, 8'h1);
      for (int c = 0; c < 4; c++) begin
         wr(5'h10, {2'(c), 2'(c)});
         step(2);
         chk(record_gain, 8'(50 * (c + 1)));
         chk({4'h0, osc_trim_pct}, {4'h0, tr[c]});
      end
      wr(5'h11, 4'h7);
      chk({7'h0, record_gain_enable}, 8'h0);
      chk({7'h0, sample_format_select}, 8'h1);
      sample_hi = 4'hb;
      step(2);
      chk(record_gain, 8'h0);
      chk({4'h0, sample_hi_twos}, 8'h0b);
      rd(5'h11, 4'h7);
      wr(5'h11, 4'h0);
      chk({7'h0, sample_format_select}, 8'h0);
      step(3);
      chk({4'h0, sample_hi_twos}, 8'h0d);
      sample_hi = 4'h3;
      step(2);
      chk({4'h0, sample_hi_twos}, 8'h03);
      for (int s = 0; s < 4; s++) begin
         wr(5'h12, {1'b0, 2'(s), 1'b1});
         step(1);
         chk({5'h0, wake_sensitivity_select, speaker_wake_enable}, 8'(2 * s + 1));
      end
      pulse();
      rd(5'h12, 4'hf);
      rd(5'h12, 4'hf);
      wr(5'h12, 4'h7);
      rd(5'h12, 4'h7);
      wr(5'h12, 4'h0);
      pulse();
      rd(5'h12, 4'h0);
      wr(5'h12, 4'h1);
      halt_wake_spk = 1'b1;
      wr(5'h12, 4'h1);
      halt_wake_spk = 1'b0;
      rd(5'h12, 4'h9);
      low_voltage_sense = 1'b1;
      rd(5'h13, 4'h0);
      wr(5'h13, 4'hf);
      chk({7'h0, low_voltage_detect_enable}, 8'h1);
      rd(5'h13, 4'h3);
      low_voltage_sense = 1'b0;
      wr(5'h13, 4'h3);
      rd(5'h13, 4'h1);
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      rd(5'h13, 4'h0);
      rd(5'h12, 4'h0);
      complete_run();
   end
endmodule // tb
